// [hw/plcfg_top.sv]
// Configuration bank, reference counter, lock detector and status pin of the synthesizer.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`include "plcfg_cfg.svh"

module plcfg_top (
  input  wire logic                 mclk,            // 40 MHz clock
  input  wire logic                 rst,             // Asynchronous reset, active high
  input  wire logic [7:0]           reg_addr,        // Register byte address
  input  wire logic [31:0]          reg_wdata,       // Write data
  input  wire logic                 reg_wr,          // Write strobe
  input  wire logic                 reg_rd,          // Read strobe
  output logic      [31:0]          reg_rdata,       // Read data, cycle after strobe
  input  wire logic                 ref_tick,        // One pulse per reference edge
  input  wire logic                 fb_div_out,      // Feedback counter output
  input  wire logic                 pfd_tick,        // One pulse per detector cycle
  input  wire logic                 phase_err_lt6,   // Phase error under 6 ns
  input  wire logic                 phase_err_lt10,  // Phase error under 10 ns
  input  wire logic                 readback_data,   // Serial read-back bit
  output logic                      status_pin_o,    // Status pin level
  output logic                      status_pin_oe,   // Status pin driven
  output logic                      ref_div_out,     // Reference counter pulse
  output logic                      locked_o,        // Lock indication
  output plcfg_pkg::plcfg_ref_type  ref_cfg_o,       // First word fields
  output plcfg_pkg::plcfg_band_type band_cfg_o,      // Second word fields
  output logic      [2:0]           out_div_sel_o    // Applied output divide select
);
  import plcfg_pkg::*;

  localparam plcfg_ref_type REF_RST = '{
    status_pin_selector:      `PLCFG_SEL_HIZ,
    reference_doubler_enable: 1'b0,
    reference_halver_enable:  1'b0,
    ref_divide:               `PLCFG_R_RST,
    shadow_update_enable:     1'b0,
    pump_current_code:        4'h0,
    lock_cycle_count_select:  1'b0,
    lock_window_select:       1'b0,
    detector_polarity:        `PLCFG_POL_RST,
    power_down_request:       1'b0,
    pump_tristate:            1'b0
  };

  localparam plcfg_band_type BAND_RST = '{
    band_seq_rate_select: 1'b0,
    divider_mode_select:  2'h0,
    divider_count_value:  `PLCFG_DIV_RST
  };

  plcfg_ref_type  ref_q;
  plcfg_ref_type  ref_d;
  plcfg_band_type band_q;
  plcfg_band_type band_d;
  plcfg_lock_type lock_q;
  logic [2:0]     odiv_q;
  logic [2:0]     shadow_q;
  logic           pending_q;
  logic [9:0]     rcnt_q;
  logic           rpulse_q;
  logic [5:0]     lcnt_q;
  logic           pin_q;
  logic           oe_q;
  logic [31:0]    rdata_q;
  logic           pin_d;
  logic           oe_d;
  logic [31:0]    rdata_d;

  // Write decode: one programming port, the code in the low bits picks the word.
  wire       prog_wr   = reg_wr && (reg_addr == `PLCFG_ADDR_PROG);
  wire [2:0] code      = reg_wdata[2:0];
  wire       ref_load  = prog_wr && (code == `PLCFG_CODE_REF);
  wire       band_load = prog_wr && (code == `PLCFG_CODE_BAND);
  wire       freq_wr   = prog_wr && (code == `PLCFG_CODE_FREQ);
  wire [2:0] odiv_new  = reg_wdata[`PLCFG_ODIV_HI:`PLCFG_ODIV_LO];
  wire       odiv_wr   = prog_wr && (code == `PLCFG_CODE_ODIV) &&
                         (odiv_new != `PLCFG_ODIV_RSV);
  wire       shd_en    = ref_q.shadow_update_enable;

  assign ref_d.status_pin_selector      = reg_wdata[`PLCFG_SEL_HI:`PLCFG_SEL_LO];
  assign ref_d.reference_doubler_enable = reg_wdata[`PLCFG_DBL_BIT];
  assign ref_d.reference_halver_enable  = reg_wdata[`PLCFG_HALF_BIT];
  assign ref_d.ref_divide               = reg_wdata[`PLCFG_R_HI:`PLCFG_R_LO];
  assign ref_d.shadow_update_enable     = reg_wdata[`PLCFG_SHD_BIT];
  assign ref_d.pump_current_code        = reg_wdata[`PLCFG_CP_HI:`PLCFG_CP_LO];
  assign ref_d.lock_cycle_count_select  = reg_wdata[`PLCFG_LCNT_BIT];
  assign ref_d.lock_window_select       = reg_wdata[`PLCFG_LWIN_BIT];
  assign ref_d.detector_polarity        = reg_wdata[`PLCFG_POL_BIT];
  assign ref_d.power_down_request       = reg_wdata[`PLCFG_PD_BIT];
  assign ref_d.pump_tristate            = reg_wdata[`PLCFG_TRI_BIT];

  assign band_d.band_seq_rate_select = reg_wdata[`PLCFG_RATE_BIT];
  assign band_d.divider_mode_select  = reg_wdata[`PLCFG_MODE_HI:`PLCFG_MODE_LO];
  assign band_d.divider_count_value  = reg_wdata[`PLCFG_DIV_HI:`PLCFG_DIV_LO];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_q  <= REF_RST;
      band_q <= BAND_RST;
    end else begin
      if (ref_load) begin
        ref_q <= ref_d;
      end
      if (band_load) begin
        band_q <= band_d;
      end
    end
  end

  // Output divide select: direct, or parked until the next frequency word write.
  wire       odiv_apply = (odiv_wr && !shd_en) || (freq_wr && pending_q);
  wire [2:0] odiv_d     = (odiv_wr && !shd_en) ? odiv_new : shadow_q;
  wire       pend_d     = (odiv_wr && shd_en) ? 1'b1 : (freq_wr ? 1'b0 : pending_q);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      odiv_q    <= `PLCFG_ODIV_RST;
      shadow_q  <= `PLCFG_ODIV_RST;
      pending_q <= 1'b0;
    end else begin
      if (odiv_wr) begin
        shadow_q <= odiv_new;
      end
      if (odiv_apply) begin
        odiv_q <= odiv_d;
      end
      pending_q <= pend_d;
    end
  end

  // Reference counter: one output pulse every ref_divide reference edges.
  wire [10:0] rcnt_inc = {1'b0, rcnt_q} + 11'h001;
  wire        r_term   = rcnt_inc >= {1'b0, ref_q.ref_divide};
  wire        pd       = ref_q.power_down_request;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rcnt_q   <= 10'h000;
      rpulse_q <= 1'b0;
    end else if (pd) begin
      rcnt_q   <= 10'h000;
      rpulse_q <= 1'b0;
    end else begin
      rpulse_q <= ref_tick && r_term;
      if (ref_tick) begin
        rcnt_q <= r_term ? 10'h000 : rcnt_inc[9:0];
      end
    end
  end

  // Lock detector: lock after the chosen run of in-window detector cycles.
  wire [5:0] lock_need = ref_q.lock_cycle_count_select ? `PLCFG_LOCK_FAST
                                                       : `PLCFG_LOCK_SLOW;
  wire       in_win    = ref_q.lock_window_select ? phase_err_lt6
                                                  : phase_err_lt10;
  wire [5:0] lcnt_inc  = lcnt_q + 6'h01;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lock_q <= PLCFG_HUNT;
      lcnt_q <= 6'h00;
    end else if (pd) begin
      lock_q <= PLCFG_HUNT;
      lcnt_q <= 6'h00;
    end else if (pfd_tick) begin
      case (lock_q)
        PLCFG_HUNT: begin
          if (!in_win) begin
            lcnt_q <= 6'h00;
          end else if (lcnt_inc >= lock_need) begin
            lock_q <= PLCFG_LOCKED;
            lcnt_q <= 6'h00;
          end else begin
            lcnt_q <= lcnt_inc;
          end
        end
        PLCFG_LOCKED: begin
          if (!in_win) begin
            lock_q <= PLCFG_HUNT;
          end
        end
        default: begin
          lock_q <= PLCFG_HUNT;
          lcnt_q <= 6'h00;
        end
      endcase
    end
  end

  wire locked = (lock_q == PLCFG_LOCKED);

  // Status pin selection; the reserved code floats the pin.
  always_comb begin
    pin_d = 1'b0;
    oe_d  = 1'b1;
    case (ref_q.status_pin_selector)
      `PLCFG_SEL_HIZ:  oe_d  = 1'b0;
      `PLCFG_SEL_HIGH: pin_d = 1'b1;
      `PLCFG_SEL_LOW:  pin_d = 1'b0;
      `PLCFG_SEL_RCNT: pin_d = rpulse_q;
      `PLCFG_SEL_NCNT: pin_d = fb_div_out;
      `PLCFG_SEL_LOCK: pin_d = locked;
      `PLCFG_SEL_SDO:  pin_d = readback_data;
      default:         oe_d  = 1'b0;
    endcase
  end

  // Read-back mux; unmapped addresses read zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (reg_addr)
      `PLCFG_ADDR_REF: begin
        rdata_d[`PLCFG_SEL_HI:`PLCFG_SEL_LO] = ref_q.status_pin_selector;
        rdata_d[`PLCFG_DBL_BIT]              = ref_q.reference_doubler_enable;
        rdata_d[`PLCFG_HALF_BIT]             = ref_q.reference_halver_enable;
        rdata_d[`PLCFG_R_HI:`PLCFG_R_LO]     = ref_q.ref_divide;
        rdata_d[`PLCFG_SHD_BIT]              = ref_q.shadow_update_enable;
        rdata_d[`PLCFG_CP_HI:`PLCFG_CP_LO]   = ref_q.pump_current_code;
        rdata_d[`PLCFG_LCNT_BIT]             = ref_q.lock_cycle_count_select;
        rdata_d[`PLCFG_LWIN_BIT]             = ref_q.lock_window_select;
        rdata_d[`PLCFG_POL_BIT]              = ref_q.detector_polarity;
        rdata_d[`PLCFG_PD_BIT]               = ref_q.power_down_request;
        rdata_d[`PLCFG_TRI_BIT]              = ref_q.pump_tristate;
        rdata_d[2:0]                         = `PLCFG_CODE_REF;
      end
      `PLCFG_ADDR_BAND: begin
        rdata_d[`PLCFG_RATE_BIT]             = band_q.band_seq_rate_select;
        rdata_d[`PLCFG_MODE_HI:`PLCFG_MODE_LO] = band_q.divider_mode_select;
        rdata_d[`PLCFG_DIV_HI:`PLCFG_DIV_LO] = band_q.divider_count_value;
        rdata_d[2:0]                         = `PLCFG_CODE_BAND;
      end
      `PLCFG_ADDR_ODIV: begin
        rdata_d[2:0] = odiv_q;
        rdata_d[6:4] = shadow_q;
        rdata_d[8]   = pending_q;
      end
      `PLCFG_ADDR_STAT: begin
        rdata_d[0] = locked;
        rdata_d[1] = pin_q;
        rdata_d[2] = oe_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_q   <= 1'b0;
      oe_q    <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      pin_q   <= pin_d;
      oe_q    <= oe_d;
      rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
    end
  end

  assign reg_rdata     = rdata_q;
  assign status_pin_o  = pin_q;
  assign status_pin_oe = oe_q;
  assign ref_div_out   = rpulse_q;
  assign locked_o      = locked;
  assign ref_cfg_o     = ref_q;
  assign band_cfg_o    = band_q;
  assign out_div_sel_o = odiv_q;

endmodule : plcfg_top

// [hw/plcfg_cfg.svh]
// Offsets, field positions, codes, reset values and lock counts of the synthesizer config bank.
// What this block does
// - Selector 000 floats, 001 high, 010 low.
// - 011 reference counter, 100 feedback, 101 reserved.
// - 110 lock indication, 111 serial read-back.
// - Reference doubler enable, default off.
// - Reference halver enable, default off.
// - Ten-bit reference divide, default 1; zero is stored and divides by 1.
// - Bit D13 enables output divider double buffering.
// - Four-bit pump current code, default 0000.
// - Lock after 40 or 5 consecutive cycles.
// - Lock window 10ns default, 6ns when set.
// - Detector polarity defaults positive, 0 negative.
// - Power-down bit, default not powered down.
// - Pump tri-state bit, default disabled.
// - Code 010 loads the first word.
// - Band sequence rate slow default, fast when set.
// - Divider mode off, fast lock, resync, reserved.
// - Twelve-bit divider value, default 1; zero is stored as written.
// - Second word fields at D23, D16:D15, D14:D3.
// - Code 011 loads the second word.
// - Output divide select, code 111 reserved.
`ifndef PLCFG_CFG_SVH
`define PLCFG_CFG_SVH

`define PLCFG_ADDR_PROG 8'h00
`define PLCFG_ADDR_REF  8'h04
`define PLCFG_ADDR_BAND 8'h08
`define PLCFG_ADDR_ODIV 8'h0C
`define PLCFG_ADDR_STAT 8'h10

`define PLCFG_CODE_FREQ 3'h0
`define PLCFG_CODE_REF  3'h2
`define PLCFG_CODE_BAND 3'h3
`define PLCFG_CODE_ODIV 3'h4

`define PLCFG_SEL_HIZ  3'h0
`define PLCFG_SEL_HIGH 3'h1
`define PLCFG_SEL_LOW  3'h2
`define PLCFG_SEL_RCNT 3'h3
`define PLCFG_SEL_NCNT 3'h4
`define PLCFG_SEL_LOCK 3'h6
`define PLCFG_SEL_SDO  3'h7

`define PLCFG_SEL_HI   28
`define PLCFG_SEL_LO   26
`define PLCFG_DBL_BIT  25
`define PLCFG_HALF_BIT 24
`define PLCFG_R_HI     23
`define PLCFG_R_LO     14
`define PLCFG_SHD_BIT  13
`define PLCFG_CP_HI    12
`define PLCFG_CP_LO    9
`define PLCFG_LCNT_BIT 8
`define PLCFG_LWIN_BIT 7
`define PLCFG_POL_BIT  6
`define PLCFG_PD_BIT   5
`define PLCFG_TRI_BIT  4

`define PLCFG_RATE_BIT 23
`define PLCFG_MODE_HI  16
`define PLCFG_MODE_LO  15
`define PLCFG_DIV_HI   14
`define PLCFG_DIV_LO   3

`define PLCFG_ODIV_HI  22
`define PLCFG_ODIV_LO  20
`define PLCFG_ODIV_RSV 3'h7

`define PLCFG_R_RST    10'h001
`define PLCFG_DIV_RST  12'h001
`define PLCFG_POL_RST  1'b1
`define PLCFG_ODIV_RST 3'h0

`define PLCFG_LOCK_SLOW 6'h28
`define PLCFG_LOCK_FAST 6'h05

`endif

// [hw/plcfg_pkg.sv]
// Types shared by the synthesizer configuration bank.
package plcfg_pkg;

  typedef struct packed {
    logic [2:0] status_pin_selector;
    logic       reference_doubler_enable;
    logic       reference_halver_enable;
    logic [9:0] ref_divide;
    logic       shadow_update_enable;
    logic [3:0] pump_current_code;
    logic       lock_cycle_count_select;
    logic       lock_window_select;
    logic       detector_polarity;
    logic       power_down_request;
    logic       pump_tristate;
  } plcfg_ref_type;

  typedef struct packed {
    logic        band_seq_rate_select;
    logic [1:0]  divider_mode_select;
    logic [11:0] divider_count_value;
  } plcfg_band_type;

  typedef enum logic {
    PLCFG_HUNT,
    PLCFG_LOCKED
  } plcfg_lock_type;

endpackage : plcfg_pkg

// [sim/plcfg_checker.sv]
// Port-level assertions for the synthesizer configuration bank.
module plcfg_checker
  import plcfg_pkg::*;
(
  input wire logic                     mclk,          // Clock
  input wire logic                     rst,           // Reset
  input wire logic [7:0]               reg_addr,      // Address
  input wire logic [31:0]              reg_wdata,     // Write data
  input wire logic                     reg_wr,        // Write strobe
  input wire logic                     fb_div_out,    // Feedback level
  input wire logic                     readback_data, // Read-back bit
  input wire logic                     status_pin_o,  // Pin level
  input wire logic                     status_pin_oe, // Pin driven
  input wire logic                     locked_o,      // Lock
  input wire plcfg_pkg::plcfg_ref_type  ref_cfg_o,     // First word
  input wire plcfg_pkg::plcfg_band_type band_cfg_o,    // Second word
  input wire logic [2:0]               out_div_sel_o  // Divide select
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire       w_prog = reg_wr && reg_addr == 8'h00;
  wire       w_ref  = w_prog && reg_wdata[2:0] == 3'h2;
  wire       w_band = w_prog && reg_wdata[2:0] == 3'h3;
  wire       w_odiv = w_prog && reg_wdata[2:0] == 3'h4 && reg_wdata[22:20] != 3'h7;
  wire [2:0] sel    = ref_cfg_o.status_pin_selector;
  sequence s_direct_div;
    w_odiv && !ref_cfg_o.shadow_update_enable;
  endsequence
  sequence s_shadow_div;
    w_odiv && ref_cfg_o.shadow_update_enable;
  endsequence
  a_ref_load: assert property (w_ref |=> ref_cfg_o == $past(reg_wdata[28:4]))
    else $error("first word not loaded");
  a_ref_hold: assert property (!w_ref |=> $stable(ref_cfg_o))
    else $error("first word changed");
  a_band_load: assert property (w_band |=> band_cfg_o ==
    {$past(reg_wdata[23]), $past(reg_wdata[16:3])}) else $error("second word not loaded");
  a_band_hold: assert property (!w_band |=> $stable(band_cfg_o))
    else $error("second word changed");
  a_div_direct: assert property (s_direct_div |=>
    out_div_sel_o == $past(reg_wdata[22:20])) else $error("divide select not applied");
  a_div_shadow: assert property (s_shadow_div |=> $stable(out_div_sel_o))
    else $error("shadowed select applied early");
  a_pin_float: assert property ((sel == 3'h0 || sel == 3'h5) |=> !status_pin_oe)
    else $error("pin driven while floating");
  a_pin_high: assert property (sel == 3'h1 |=> status_pin_oe && status_pin_o)
    else $error("pin not high");
  a_pin_low: assert property (sel == 3'h2 |=> status_pin_oe && !status_pin_o)
    else $error("pin not low");
  a_pin_fb: assert property (sel == 3'h4 |=> status_pin_o == $past(fb_div_out))
    else $error("pin not feedback");
  a_pin_lock: assert property (sel == 3'h6 |=> status_pin_o == $past(locked_o))
    else $error("pin not lock");
  a_pin_sdo: assert property (sel == 3'h7 |=> status_pin_o == $past(readback_data))
    else $error("pin not read-back");
endmodule : plcfg_checker

// [sim/plcfg_host.sv]
// Host model that programs the configuration bank over the plain register port.
module plcfg_host (
  input  wire logic        mclk,      // Clock
  input  wire logic [31:0] reg_rdata, // Read data
  output logic      [7:0]  reg_addr,  // Address
  output logic      [31:0] reg_wdata, // Write data
  output logic             reg_wr,    // Write strobe
  output logic             reg_rd     // Read strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 42'h0;
  // Released address and data are inverted so stale values are never mistaken for live ones.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge mclk);
    q = reg_rdata;
  endtask : rd
endmodule : plcfg_host

// [sim/tb.sv]
// Self-checking bench for the synthesizer configuration bank.
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import plcfg_pkg::*;
  logic mclk = 0, rst = 1, ref_tick = 0, fb_div_out = 0, pfd_tick = 0;
  logic phase_err_lt6 = 0, phase_err_lt10 = 0, readback_data = 0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, status_pin_o, status_pin_oe, ref_div_out, locked_o;
  logic [2:0] out_div_sel_o, m_od = 0, m_sh = 0;
  plcfg_ref_type ref_cfg_o;
  plcfg_band_type band_cfg_o;
  logic [24:0] m_ref = 25'h0000404;
  logic [14:0] m_band = 15'h0001;
  logic m_pn = 0;
  logic [7:0] pin_exp = 8'h92;
  int errors = 0, tests_run = 0, npulse = 0, i;
  initial forever #12.5 mclk = ~mclk;
  plcfg_top i_plcfg_top (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ref_tick, .fb_div_out, .pfd_tick, .phase_err_lt6, .phase_err_lt10, .readback_data,
    .status_pin_o, .status_pin_oe, .ref_div_out, .locked_o, .ref_cfg_o, .band_cfg_o,
    .out_div_sel_o);
  plcfg_host i_plcfg_host (.mclk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  always @(posedge mclk) if (ref_div_out === 1'b1) npulse++;
  task automatic mwr(input logic [7:0] a, input logic [31:0] w);
    i_plcfg_host.wr(a, w);
    if (a == 8'h00) case (w[2:0])
      3'h2: m_ref = w[28:4];
      3'h3: m_band = {w[23], w[16:3]};
      3'h4: if (w[22:20] != 3'h7) begin
        if (m_ref[9]) begin
          m_sh = w[22:20];
          m_pn = 1;
        end else m_od = w[22:20];
      end
      3'h0: if (m_pn) begin
        m_od = m_sh;
        m_pn = 0;
      end
      default: ;
    endcase
    #1;
    `CHK("first word", m_ref, ref_cfg_o)
    `CHK("second word", m_band, band_cfg_o)
    `CHK("divide select", m_od, out_div_sel_o)
  endtask : mwr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    i_plcfg_host.rd(a, q);
    `CHK("read data", e, q & m)
  endtask : rdc
  task automatic tick(input logic g10, input logic g6);
    @(posedge mclk);
    phase_err_lt10 <= g10;
    phase_err_lt6 <= g6;
    pfd_tick <= 1'b1;
    @(posedge mclk);
    pfd_tick <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : tick
  task close_out;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    close_out;
  end
  initial begin
    i = $urandom(32'hF34F0917);
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1;
    `CHK("reset first", 25'h0000404, ref_cfg_o)
    `CHK("reset second", 15'h0001, band_cfg_o)
    `CHK("reset pin", 1'b0, status_pin_oe)
    rdc(8'h04, 32'hFFFFFFFF, 32'h00004042);
    rdc(8'h14, 32'hFFFFFFFF, 32'h0);
    for (i = 0; i < 80; i++) begin
      d = $urandom;
      d[14] = 1'b1;
      d[13] = (i >= 40);
      if (&d[19:12]) d[12] = 1'b0;
      mwr(($urandom % 4 == 0) ? 8'h04 : 8'h00, d);
      rdc(8'h08, 32'hFFFFFFFF, {8'h0, m_band[14], 6'h0, m_band[13:0], 3'h3});
      rdc(8'h0C, 32'h107, {23'h0, m_pn, 5'h0, m_od});
    end
    for (i = 0; i < 8; i++) begin
      @(posedge mclk);
      fb_div_out <= ~i[0];
      readback_data <= i[0];
      mwr(8'h00, {3'h0, i[2:0], 26'h0004042});
      repeat (2) @(posedge mclk);
      #1;
      `CHK("pin driven", !(i == 0 || i == 5), status_pin_oe)
      if (i != 0 && i != 5) `CHK("pin level", pin_exp[i], status_pin_o)
    end
    mwr(8'h00, 32'h18004142);
    repeat (4) tick(1, 0);
    `CHK("lock early", 1'b0, locked_o)
    tick(1, 0);
    `CHK("lock five", 1'b1, locked_o)
    tick(0, 1);
    `CHK("lock drop", 1'b0, locked_o)
    mwr(8'h00, 32'h180040C2);
    repeat (20) tick(1, 1);
    tick(1, 0);
    repeat (39) tick(1, 1);
    `CHK("lock early", 1'b0, locked_o)
    tick(1, 1);
    `CHK("lock forty", 1'b1, locked_o)
    rdc(8'h10, 32'hFFFFFFFF, 32'h00000007);
    mwr(8'h00, 32'h180040E2);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("power down", 1'b0, locked_o)
    mwr(8'h00, 32'h0000C042);
    npulse = 0;
    @(posedge mclk);
    repeat (9) begin
      ref_tick <= 1'b1;
      @(posedge mclk);
      ref_tick <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    repeat (2) @(posedge mclk);
    #1;
    `CHK("ref pulses", 3, npulse)
    close_out;
  end
endmodule : tb
bind plcfg_top plcfg_checker i_plcfg_checker (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .fb_div_out, .readback_data, .status_pin_o, .status_pin_oe, .locked_o, .ref_cfg_o,
  .band_cfg_o, .out_div_sel_o);
